// ### hdl/hbl_map.vh
`ifndef HBL_MAP_VH
`define HBL_MAP_VH
// register offsets
`define HBL_REG_CTRL 8'h00
`define HBL_REG_HOLD 8'h04
`define HBL_REG_IDLE 8'h08
`define HBL_REG_QUAL 8'h0C
`define HBL_REG_STAT 8'h10
`define HBL_REG_ISR 8'h14
`define HBL_REG_IMR 8'h18
// control register fields
`define HBL_CFG_LOGGED 2
`define HBL_CFG_RECOG 3
`define HBL_CFG_CPUBOOT 4
`define HBL_CFG_BOOTONLY 5
`define HBL_CFG_HMIFAIL 6
`define HBL_CFG_STUCK 7
`define HBL_CFG_WIRED 8
`define HBL_CFG_ALARMS 9
`define HBL_CFG_FWUPD 10
`define HBL_CFG_UNITFAIL 11
`define HBL_CFG_SYSBOOT 12
// quality register fields
`define HBL_Q_ALARM 0
`define HBL_Q_OVERRIDE 1
`define HBL_Q_FAULT 2
`define HBL_Q_NEEDVAL 3
`define HBL_Q_VALDONE 4
// reset values
`define HBL_HOLD_MS_RST 16'h03E8
`define HBL_IDLE_MIN_RST 8'h05
// display modes
`define HBL_MODE_IDLE 2'b00
`define HBL_MODE_SAVER 2'b01
`define HBL_MODE_ENTRY 2'b10
// led colours
`define HBL_LED_OFF 2'b00
`define HBL_LED_GREEN 2'b01
`define HBL_LED_RED 2'b10
`define HBL_LED_YELLOW 2'b11
// buttons
`define HBL_BTN_UP 0
`define HBL_BTN_DOWN 1
`define HBL_BTN_LEFT 2
`define HBL_BTN_RIGHT 3
// timing
`define HBL_CLK_NS 100
`define HBL_TICK_NS 1000000
`define HBL_POLL_MS 16'h1770
`define HBL_PULSE_MS 16'h0064
`define HBL_FLASH_MS 16'h01F4
`define HBL_SCROLL_MS 16'h0064
`define HBL_ADV_MS 16'h0BB8
`define HBL_MINUTE_MS 16'hEA60
`endif

// ### hdl/hbl_indicator.v
`timescale 1ns/1ps
`default_nettype none
`include "hbl_map.vh"
module hbl_indicator #(
    parameter TICK_CYCLES = `HBL_TICK_NS / `HBL_CLK_NS,
    parameter [15:0] POLL_MS = `HBL_POLL_MS,
    parameter [15:0] PULSE_MS = `HBL_PULSE_MS,
    parameter [15:0] FLASH_MS = `HBL_FLASH_MS,
    parameter [15:0] SCROLL_MS = `HBL_SCROLL_MS,
    parameter [15:0] ADV_MS = `HBL_ADV_MS,
    parameter [15:0] MINUTE_MS = `HBL_MINUTE_MS
) (
    input wire clk,
    input wire rst,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wrEn,
    input wire rdEn,
    output reg [31:0] rdata,
    input wire irBtnUp,
    input wire irBtnDown,
    input wire irBtnLeft,
    input wire irBtnRight,
    output reg [1:0] ledLink,
    output reg [1:0] ledInput,
    output reg [1:0] ledStatus,
    output reg [1:0] ledAlarm,
    output reg qualAlarm,
    output reg qualOverride,
    output reg qualFault,
    output reg qualUnverified,
    output reg displayOn,
    output reg [7:0] paramIdx,
    output reg [7:0] charIdx,
    output reg [7:0] cursorPos,
    output reg logoutPulse,
    output reg acceptPulse,
    output reg cancelPulse,
    output reg irq
);
    localparam [15:0] TICK_LAST = TICK_CYCLES[15:0] - 16'h0001;

    // true when a count about to be incremented reaches its limit
    function msDone;
        input [15:0] cnt;
        input [15:0] lim;
        begin
            msDone = ({1'b0, cnt} + 17'h0_0001) >= {1'b0, lim};
        end
    endfunction

    integer i;
    reg [3:0] sync1_r, sync2_r, sync3_r, btn_r, btnPrev_r;
    reg [15:0] tickCnt_r;
    reg tick_r;
    reg [15:0] pressMs_r [0:3];
    reg [3:0] holdDone_r, tapEv_r, holdEv_r;
    reg [15:0] flashMs_r, pollMs_r, pulseMs_r, scrollMs_r, advMs_r, idleMs_r;
    reg flashPhase_r, pollNow_r, pulseOn_r, scrollStep_r, advStep_r, sleepNow_r;
    reg [1:0] cyc3_r;
    reg [7:0] idleMin_r;
    reg [1:0] mode_r;
    reg loggedIn_r, wakeEv_r, sleepEv_r;
    reg [12:3] cfg_r;
    reg [15:0] holdMs_r;
    reg [7:0] idleMinutes_r;
    reg [4:0] qual_r;
    reg [6:0] isr_r, imr_r;
    reg [31:0] rdMux;
    reg [1:0] linkNxt, inputNxt, statusNxt, alarmNxt;
    wire [3:0] agree = ~(sync2_r ^ sync3_r);
    wire [3:0] pressStart = btn_r & ~btnPrev_r;
    wire upHeld = btn_r[`HBL_BTN_UP] & holdDone_r[`HBL_BTN_UP];
    wire downHeld = btn_r[`HBL_BTN_DOWN] & holdDone_r[`HBL_BTN_DOWN];
    wire frozen = (mode_r == `HBL_MODE_SAVER) & (upHeld | downHeld);
    wire wrIsr = wrEn & (addr == `HBL_REG_ISR);
    wire [6:0] events = {cancelPulse, acceptPulse, logoutPulse, sleepEv_r, wakeEv_r,
                         |holdEv_r, |tapEv_r};

    // pin synchroniser: a level is taken once stages two and three agree
    always @(posedge clk)
    begin
        if (rst)
        begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            sync3_r <= 4'h0;
            btn_r <= 4'h0;
        end
        else
        begin
            sync1_r <= {irBtnRight, irBtnLeft, irBtnDown, irBtnUp};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            btn_r <= (btn_r & ~agree) | (sync3_r & agree);
        end
    end

    // millisecond tick
    always @(posedge clk)
    begin
        if (rst)
        begin
            tickCnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end
        else if (tickCnt_r == TICK_LAST)
        begin
            tickCnt_r <= 16'h0000;
            tick_r <= 1'b1;
        end
        else
        begin
            tickCnt_r <= tickCnt_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    // tap or hold, one event per press
    always @(posedge clk)
    begin
        if (rst)
        begin
            for (i = 0; i < 4; i = i + 1)
                pressMs_r[i] <= 16'h0000;
            holdDone_r <= 4'h0;
            btnPrev_r <= 4'h0;
            tapEv_r <= 4'h0;
            holdEv_r <= 4'h0;
        end
        else
        begin
            btnPrev_r <= btn_r;
            for (i = 0; i < 4; i = i + 1)
            begin
                tapEv_r[i] <= 1'b0;
                holdEv_r[i] <= 1'b0;
                if (!btn_r[i])
                begin
                    if (btnPrev_r[i] && !holdDone_r[i])
                        tapEv_r[i] <= 1'b1;
                    pressMs_r[i] <= 16'h0000;
                    holdDone_r[i] <= 1'b0;
                end
                else if (tick_r && !holdDone_r[i])
                begin
                    pressMs_r[i] <= pressMs_r[i] + 16'h0001;
                    if (msDone(pressMs_r[i], holdMs_r))
                    begin
                        holdEv_r[i] <= 1'b1;
                        holdDone_r[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // flash phase, three-colour cycle, sleep poll, scroll and auto advance
    always @(posedge clk)
    begin
        if (rst)
        begin
            flashMs_r <= 16'h0000;
            flashPhase_r <= 1'b0;
            cyc3_r <= 2'b00;
            pollMs_r <= 16'h0000;
            pollNow_r <= 1'b0;
            pulseMs_r <= 16'h0000;
            pulseOn_r <= 1'b0;
            scrollMs_r <= 16'h0000;
            scrollStep_r <= 1'b0;
            advMs_r <= 16'h0000;
            advStep_r <= 1'b0;
        end
        else
        begin
            pollNow_r <= 1'b0;
            scrollStep_r <= 1'b0;
            advStep_r <= 1'b0;
            if (tick_r)
            begin
                flashMs_r <= flashMs_r + 16'h0001;
                if (msDone(flashMs_r, FLASH_MS))
                begin
                    flashMs_r <= 16'h0000;
                    flashPhase_r <= ~flashPhase_r;
                    cyc3_r <= (cyc3_r == 2'b10) ? 2'b00 : cyc3_r + 2'b01;
                end
            end
            if (mode_r != `HBL_MODE_IDLE)
            begin
                pollMs_r <= 16'h0000;
                pulseOn_r <= 1'b0;
            end
            else if (tick_r)
            begin
                pollMs_r <= pollMs_r + 16'h0001;
                if (msDone(pollMs_r, POLL_MS))
                begin
                    pollMs_r <= 16'h0000;
                    pollNow_r <= 1'b1;
                    pulseOn_r <= 1'b1;
                    pulseMs_r <= 16'h0000;
                end
                else if (pulseOn_r)
                begin
                    pulseMs_r <= pulseMs_r + 16'h0001;
                    if (msDone(pulseMs_r, PULSE_MS))
                        pulseOn_r <= 1'b0;
                end
            end
            if (mode_r != `HBL_MODE_ENTRY || !(upHeld || downHeld))
                scrollMs_r <= 16'h0000;
            else if (tick_r)
            begin
                scrollMs_r <= scrollMs_r + 16'h0001;
                if (msDone(scrollMs_r, SCROLL_MS))
                begin
                    scrollMs_r <= 16'h0000;
                    scrollStep_r <= 1'b1;
                end
            end
            if (mode_r != `HBL_MODE_SAVER || frozen)
                advMs_r <= 16'h0000;
            else if (tick_r)
            begin
                advMs_r <= advMs_r + 16'h0001;
                if (msDone(advMs_r, ADV_MS))
                begin
                    advMs_r <= 16'h0000;
                    advStep_r <= 1'b1;
                end
            end
        end
    end

    // inactivity timer
    always @(posedge clk)
    begin
        if (rst)
        begin
            idleMs_r <= 16'h0000;
            idleMin_r <= 8'h00;
            sleepNow_r <= 1'b0;
        end
        else
        begin
            sleepNow_r <= 1'b0;
            if (mode_r == `HBL_MODE_IDLE || |pressStart || idleMinutes_r == 8'h00)
            begin
                idleMs_r <= 16'h0000;
                idleMin_r <= 8'h00;
            end
            else if (tick_r)
            begin
                idleMs_r <= idleMs_r + 16'h0001;
                if (msDone(idleMs_r, MINUTE_MS))
                begin
                    idleMs_r <= 16'h0000;
                    idleMin_r <= idleMin_r + 8'h01;
                    if (msDone({8'h00, idleMin_r}, {8'h00, idleMinutes_r}))
                    begin
                        sleepNow_r <= 1'b1;
                        idleMin_r <= 8'h00;
                    end
                end
            end
        end
    end

    // display mode and button actions
    always @(posedge clk)
    begin
        if (rst)
        begin
            mode_r <= `HBL_MODE_SAVER;
            loggedIn_r <= 1'b0;
            paramIdx <= 8'h00;
            charIdx <= 8'h00;
            cursorPos <= 8'h00;
            logoutPulse <= 1'b0;
            acceptPulse <= 1'b0;
            cancelPulse <= 1'b0;
            wakeEv_r <= 1'b0;
            sleepEv_r <= 1'b0;
        end
        else
        begin
            logoutPulse <= 1'b0;
            acceptPulse <= 1'b0;
            cancelPulse <= 1'b0;
            wakeEv_r <= 1'b0;
            sleepEv_r <= 1'b0;
            if (wrEn && addr == `HBL_REG_CTRL)
            begin
                mode_r <= wdata[1:0];
                loggedIn_r <= wdata[`HBL_CFG_LOGGED];
            end
            case (mode_r)
                `HBL_MODE_IDLE:
                begin
                    if (holdEv_r[`HBL_BTN_UP] || holdEv_r[`HBL_BTN_DOWN] ||
                        (pollNow_r && btn_r[`HBL_BTN_LEFT]))
                    begin
                        mode_r <= `HBL_MODE_SAVER;
                        wakeEv_r <= 1'b1;
                    end
                end
                `HBL_MODE_SAVER:
                begin
                    if (tapEv_r[`HBL_BTN_UP])
                        paramIdx <= paramIdx - 8'h01;
                    else if (tapEv_r[`HBL_BTN_DOWN] || advStep_r)
                        paramIdx <= paramIdx + 8'h01;
                    if ((tapEv_r[`HBL_BTN_LEFT] || holdEv_r[`HBL_BTN_LEFT]) && loggedIn_r)
                    begin
                        loggedIn_r <= 1'b0;
                        logoutPulse <= 1'b1;
                    end
                    if (sleepNow_r)
                    begin
                        mode_r <= `HBL_MODE_IDLE;
                        sleepEv_r <= 1'b1;
                    end
                end
                `HBL_MODE_ENTRY:
                begin
                    if (tapEv_r[`HBL_BTN_UP] || (scrollStep_r && upHeld))
                        charIdx <= charIdx - 8'h01;
                    else if (tapEv_r[`HBL_BTN_DOWN] || (scrollStep_r && downHeld))
                        charIdx <= charIdx + 8'h01;
                    if (tapEv_r[`HBL_BTN_LEFT])
                        cursorPos <= cursorPos - 8'h01;
                    else if (tapEv_r[`HBL_BTN_RIGHT])
                        cursorPos <= cursorPos + 8'h01;
                    acceptPulse <= holdEv_r[`HBL_BTN_LEFT];
                    cancelPulse <= holdEv_r[`HBL_BTN_RIGHT];
                    if (sleepNow_r)
                    begin
                        mode_r <= `HBL_MODE_IDLE;
                        sleepEv_r <= 1'b1;
                    end
                end
                default:
                    mode_r <= `HBL_MODE_IDLE;
            endcase
        end
    end

    // register file and interrupt status
    always @*
    begin
        case (addr)
            `HBL_REG_CTRL: rdMux = {19'h0_0000, cfg_r, loggedIn_r, mode_r};
            `HBL_REG_HOLD: rdMux = {16'h0000, holdMs_r};
            `HBL_REG_IDLE: rdMux = {24'h00_0000, idleMinutes_r};
            `HBL_REG_QUAL: rdMux = {27'h000_0000, qual_r};
            `HBL_REG_STAT: rdMux = {cursorPos, charIdx, paramIdx, 1'b0, frozen, mode_r, btn_r};
            `HBL_REG_ISR: rdMux = {25'h000_0000, isr_r};
            `HBL_REG_IMR: rdMux = {25'h000_0000, imr_r};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            cfg_r <= 10'h000;
            holdMs_r <= `HBL_HOLD_MS_RST;
            idleMinutes_r <= `HBL_IDLE_MIN_RST;
            qual_r <= 5'h00;
            isr_r <= 7'h00;
            imr_r <= 7'h00;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            rdata <= rdEn ? rdMux : 32'h0000_0000;
            if (wrEn && addr == `HBL_REG_CTRL)
                cfg_r <= wdata[12:3];
            if (wrEn && addr == `HBL_REG_HOLD)
                holdMs_r <= wdata[15:0];
            if (wrEn && addr == `HBL_REG_IDLE)
                idleMinutes_r <= wdata[7:0];
            if (wrEn && addr == `HBL_REG_QUAL)
                qual_r <= wdata[4:0];
            if (wrEn && addr == `HBL_REG_IMR)
                imr_r <= wdata[6:0];
            // a new event wins over a clear in the same cycle
            isr_r <= (isr_r & ~(wrIsr ? wdata[6:0] : 7'h00)) | events;
        end
    end

    // indicator colours
    always @*
    begin
        linkNxt = cfg_r[`HBL_CFG_WIRED] ? `HBL_LED_GREEN : `HBL_LED_OFF;
        if (!cfg_r[`HBL_CFG_RECOG] || cfg_r[`HBL_CFG_CPUBOOT])
            inputNxt = flashPhase_r ? `HBL_LED_YELLOW : `HBL_LED_OFF;
        else
            inputNxt = (|btn_r) ? `HBL_LED_GREEN : `HBL_LED_OFF;
        if (cfg_r[`HBL_CFG_BOOTONLY])
            statusNxt = (cyc3_r == 2'b00) ? `HBL_LED_RED :
                        (cyc3_r == 2'b01) ? `HBL_LED_GREEN : `HBL_LED_YELLOW;
        else if (cfg_r[`HBL_CFG_UNITFAIL])
            statusNxt = `HBL_LED_RED;
        else if (mode_r == `HBL_MODE_IDLE)
            statusNxt = pulseOn_r ? `HBL_LED_GREEN : `HBL_LED_OFF;
        else if (cfg_r[`HBL_CFG_SYSBOOT])
            statusNxt = flashPhase_r ? `HBL_LED_GREEN : `HBL_LED_OFF;
        else
            statusNxt = `HBL_LED_GREEN;
        if (cfg_r[`HBL_CFG_FWUPD])
            alarmNxt = flashPhase_r ? `HBL_LED_RED : `HBL_LED_OFF;
        else
            alarmNxt = cfg_r[`HBL_CFG_ALARMS] ? `HBL_LED_RED : `HBL_LED_GREEN;
        if (cfg_r[`HBL_CFG_HMIFAIL])
        begin
            linkNxt = `HBL_LED_RED;
            inputNxt = `HBL_LED_RED;
            statusNxt = `HBL_LED_RED;
            alarmNxt = `HBL_LED_RED;
        end
        else if (cfg_r[`HBL_CFG_STUCK])
        begin
            linkNxt = flashPhase_r ? `HBL_LED_RED : `HBL_LED_OFF;
            alarmNxt = flashPhase_r ? `HBL_LED_OFF : `HBL_LED_RED;
        end
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            ledLink <= `HBL_LED_OFF;
            ledInput <= `HBL_LED_OFF;
            ledStatus <= `HBL_LED_OFF;
            ledAlarm <= `HBL_LED_OFF;
            qualAlarm <= 1'b0;
            qualOverride <= 1'b0;
            qualFault <= 1'b0;
            qualUnverified <= 1'b0;
            displayOn <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            ledLink <= linkNxt;
            ledInput <= inputNxt;
            ledStatus <= statusNxt;
            ledAlarm <= alarmNxt;
            qualAlarm <= qual_r[`HBL_Q_ALARM];
            qualOverride <= qual_r[`HBL_Q_OVERRIDE];
            qualFault <= qual_r[`HBL_Q_FAULT];
            qualUnverified <= qual_r[`HBL_Q_NEEDVAL] & ~qual_r[`HBL_Q_VALDONE];
            displayOn <= (mode_r != `HBL_MODE_IDLE);
            irq <= |(isr_r & imr_r);
        end
    end
endmodule // hbl_indicator
`default_nettype wire

// ### dv/hbl_indicator_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbl_map.vh"
module hbl_indicator_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [31:0] rdata,
    input wire logic irBtnUp,
    input wire logic irBtnDown,
    input wire logic irBtnLeft,
    input wire logic irBtnRight,
    input wire logic [1:0] ledLink,
    input wire logic [1:0] ledInput,
    input wire logic [1:0] ledStatus,
    input wire logic [1:0] ledAlarm,
    input wire logic qualAlarm,
    input wire logic qualOverride,
    input wire logic qualFault,
    input wire logic qualUnverified,
    input wire logic logoutPulse,
    input wire logic acceptPulse,
    input wire logic cancelPulse,
    input wire logic irq
);
    logic [12:0] ctl_r;
    logic [12:0] ctlOld_r;
    logic [6:0] imr_r;
    logic [1:0] up_r;
    // control shadow unchanged for a cycle, well after reset
    wire settled = up_r == 2'h3 && ctl_r == ctlOld_r;
    wire anyBtn = irBtnUp | irBtnDown | irBtnLeft | irBtnRight;
    wire inLit = settled && ctl_r[3] && !ctl_r[4] && ctl_r[7:6] == 2'h0 && anyBtn;
    always @(posedge clk)
    begin
        if (rst)
        begin
            ctl_r <= 13'h0;
            ctlOld_r <= 13'h0;
            imr_r <= 7'h0;
            up_r <= 2'h0;
        end
        else
        begin
            if (wrEn && addr == `HBL_REG_CTRL)
                ctl_r <= wdata[12:0];
            if (wrEn && addr == `HBL_REG_IMR)
                imr_r <= wdata[6:0];
            ctlOld_r <= ctl_r;
            up_r <= up_r + {1'b0, up_r != 2'h3};
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    pulse_once_a: assert property (
        (logoutPulse | acceptPulse | cancelPulse) |=> !(logoutPulse | acceptPulse | cancelPulse))
        else $error("action pulse longer than one cycle");
    fail_red_a: assert property (
        settled && ctl_r[6] |-> {ledLink, ledInput, ledStatus, ledAlarm} == 8'hAA)
        else $error("failure pattern not all red");
    stuck_alt_a: assert property (
        settled && !ctl_r[6] && ctl_r[7] |-> !(ledLink == `HBL_LED_RED && ledAlarm == `HBL_LED_RED))
        else $error("link and alarm red together");
    alarm_led_a: assert property (
        settled && ctl_r[7:6] == 2'h0 && !ctl_r[10]
        |-> ledAlarm == (ctl_r[9] ? `HBL_LED_RED : `HBL_LED_GREEN))
        else $error("alarm led wrong");
    link_led_a: assert property (
        settled && ctl_r[7:6] == 2'h0 |-> ledLink == (ctl_r[8] ? `HBL_LED_GREEN : `HBL_LED_OFF))
        else $error("link led wrong");
    unit_red_a: assert property (
        settled && ctl_r[7:5] == 3'h0 && ctl_r[11] |-> ledStatus == `HBL_LED_RED)
        else $error("status led not red on unit failure");
    input_lit_a: assert property (
        inLit[*8] |-> ledInput == `HBL_LED_GREEN)
        else $error("input led not green while pressed");
    qual_copy_a: assert property (
        wrEn && addr == `HBL_REG_QUAL |-> ##2 {qualUnverified, qualFault, qualOverride, qualAlarm}
        == {$past(wdata[3], 2) & ~$past(wdata[4], 2), $past(wdata[2:0], 2)})
        else $error("quality markers wrong");
    rdata_idle_a: assert property (
        !rdEn |=> rdata == 32'h0)
        else $error("read data outside read cycle");
    irq_mask_a: assert property (
        imr_r == 7'h0 && $past(imr_r) == 7'h0 |-> !irq)
        else $error("interrupt with empty mask");
    cover property (acceptPulse);
    cover property (cancelPulse);
    cover property (logoutPulse);
    cover property (settled && ctl_r[7]);
endmodule // hbl_indicator_chk
bind hbl_indicator hbl_indicator_chk u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wrEn(wrEn), .rdEn(rdEn), .rdata(rdata), .irBtnUp(irBtnUp), .irBtnDown(irBtnDown),
    .irBtnLeft(irBtnLeft), .irBtnRight(irBtnRight), .ledLink(ledLink), .ledInput(ledInput),
    .ledStatus(ledStatus), .ledAlarm(ledAlarm), .qualAlarm(qualAlarm),
    .qualOverride(qualOverride), .qualFault(qualFault), .qualUnverified(qualUnverified),
    .logoutPulse(logoutPulse), .acceptPulse(acceptPulse), .cancelPulse(cancelPulse), .irq(irq));
`default_nettype wire

// ### dv/hbl_operator.sv
`timescale 1ns/1ps
`default_nettype none
module hbl_operator (
    input wire logic clk,
    output logic [3:0] btn
);
    initial btn = 4'h0;
    // finger on one button for n cycles, then lift and let the block settle
    task automatic press(input int idx, input int n);
        @(posedge clk);
        btn[idx] <= 1'b1;
        repeat (n) @(posedge clk);
        btn[idx] <= 1'b0;
        repeat (16) @(posedge clk);
        #1;
    endtask
endmodule // hbl_operator
`default_nettype wire

// ### dv/hbl_indicator_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbl_map.vh"
module hbl_indicator_tb;
    logic clk;
    logic rst;
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] got;
    logic [15:0] seen;
    logic bothRed;
    wire [31:0] rdata;
    wire [1:0] ledLink, ledInput, ledStatus, ledAlarm;
    wire [3:0] btn;
    wire [3:0] qual;
    wire [7:0] paramIdx, charIdx, cursorPos;
    wire displayOn, logoutPulse, acceptPulse, cancelPulse, irq;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    int nAcc = 0;
    int nCan = 0;
    int nOut = 0;
    int n;
    logic [15:0] ctlTab [10] = '{16'h0001, 16'h0009, 16'h0309, 16'h0409, 16'h1009,
        16'h0809, 16'h0029, 16'h0049, 16'h0089, 16'h0019};
    // colours seen, one-hot nibbles: alarm, status, input, link
    logic [15:0] expTab [10] = '{16'h2291, 16'h2211, 16'h4212, 16'h5211, 16'h2311,
        16'h2411, 16'h2E11, 16'h4444, 16'h5215, 16'h2291};
    hbl_indicator #(.TICK_CYCLES(4), .POLL_MS(16'h0006), .PULSE_MS(16'h0003),
        .FLASH_MS(16'h0004),
        .MINUTE_MS(16'h000A)) u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wrEn(wrEn), .rdEn(rdEn), .rdata(rdata), .irBtnUp(btn[0]), .irBtnDown(btn[1]),
        .irBtnLeft(btn[2]), .irBtnRight(btn[3]), .ledLink(ledLink), .ledInput(ledInput),
        .ledStatus(ledStatus), .ledAlarm(ledAlarm), .qualAlarm(qual[0]),
        .qualOverride(qual[1]), .qualFault(qual[2]), .qualUnverified(qual[3]),
        .displayOn(displayOn), .paramIdx(paramIdx), .charIdx(charIdx),
        .cursorPos(cursorPos), .logoutPulse(logoutPulse), .acceptPulse(acceptPulse),
        .cancelPulse(cancelPulse), .irq(irq));
    hbl_operator u_op (.clk(clk), .btn(btn));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        nAcc <= nAcc + acceptPulse;
        nCan <= nCan + cancelPulse;
        nOut <= nOut + logoutPulse;
        if (cyc == 10000)
        begin
            err_total = err_total + 1;
            stop_test;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seenV);
        num_checks++;
        if (seenV !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seenV);
        end
    endtask
    task automatic busWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask
    task automatic busRd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic watch(input int cycles);
        seen = 16'h0;
        bothRed = 1'b0;
        repeat (2) @(posedge clk);
        repeat (cycles)
        begin
            @(posedge clk);
            #1;
            seen[ledLink] = 1'b1;
            seen[4 + ledInput] = 1'b1;
            seen[8 + ledStatus] = 1'b1;
            seen[12 + ledAlarm] = 1'b1;
            if (ledLink == `HBL_LED_RED && ledAlarm == `HBL_LED_RED)
                bothRed = 1'b1;
        end
    endtask
    task automatic t_reset;
        busRd(`HBL_REG_HOLD);
        chk("hold", 32'h0000_03E8, got);
        busRd(`HBL_REG_IDLE);
        chk("idle", 32'h0000_0005, got);
        busRd(`HBL_REG_STAT);
        chk("mode", 32'h1, got[5:4]);
        busWr(`HBL_REG_IDLE, 32'h0);
        busWr(`HBL_REG_HOLD, 32'h3);
        busWr(8'h1C, 32'hFFFF_FFFF);
        busRd(8'h1C);
        chk("unmapped", 32'h0, got);
    endtask
    task automatic t_leds;
        for (int i = 0; i < 10; i++)
        begin
            busWr(`HBL_REG_CTRL, ctlTab[i]);
            watch(64);
            chk("leds", expTab[i], seen);
            chk("bothRed", ctlTab[i] == 16'h0049, bothRed);
        end
        busWr(`HBL_REG_CTRL, 32'h9);
        fork
            u_op.press(3, 40);
            begin
                repeat (20) @(posedge clk);
                #1 chk("input", 32'h1, ledInput);
            end
        join
    endtask
    task automatic t_irq;
        busWr(`HBL_REG_ISR, 32'h7F);
        busWr(`HBL_REG_IMR, 32'h1);
        u_op.press(1, 6);
        chk("param", 32'h1, paramIdx);
        chk("irq", 32'h1, irq);
        busRd(`HBL_REG_ISR);
        chk("isr", 32'h1, got);
        busWr(`HBL_REG_IMR, 32'h0);
        repeat (2) @(posedge clk);
        #1 chk("irq", 32'h0, irq);
        busWr(`HBL_REG_IMR, 32'h1);
        busWr(`HBL_REG_ISR, 32'h1);
        busRd(`HBL_REG_ISR);
        chk("isr", 32'h0, got);
        chk("irq", 32'h0, irq);
    endtask
    task automatic t_saver;
        u_op.press(0, 6);
        u_op.press(0, 6);
        chk("param", 32'hFF, paramIdx);
        busWr(`HBL_REG_ISR, 32'h7F);
        u_op.press(1, 40);
        chk("param", 32'hFF, paramIdx);
        busRd(`HBL_REG_ISR);
        chk("isr", 32'h2, got[1:0]);
    endtask
    task automatic t_logout;
        n = nOut;
        busWr(`HBL_REG_CTRL, 32'hD);
        u_op.press(2, 6);
        busRd(`HBL_REG_CTRL);
        chk("logged", 32'h0, got[2]);
        u_op.press(2, 6);
        chk("logout", n + 1, nOut);
    endtask
    task automatic t_entry;
        busWr(`HBL_REG_CTRL, 32'hA);
        u_op.press(0, 6);
        chk("char", 32'hFF, charIdx);
        u_op.press(1, 6);
        chk("char", 32'h0, charIdx);
        u_op.press(2, 6);
        chk("cursor", 32'hFF, cursorPos);
        u_op.press(3, 6);
        chk("cursor", 32'h0, cursorPos);
        n = nAcc;
        u_op.press(2, 40);
        chk("accept", n + 1, nAcc);
        n = nCan;
        u_op.press(3, 40);
        chk("cancel", n + 1, nCan);
        chk("cursor", 32'h0, cursorPos);
        u_op.press(1, 1400);
        chk("scroll", 32'h1, charIdx > 8'h02);
    endtask
    task automatic t_qual;
        for (int i = 0; i < 32; i++)
        begin
            busWr(`HBL_REG_QUAL, i);
            repeat (2) @(posedge clk);
            #1 chk("qual", {i[3] & ~i[4], i[2:0]}, qual);
        end
    endtask
    task automatic t_sleep;
        busWr(`HBL_REG_CTRL, 32'h9);
        busWr(`HBL_REG_ISR, 32'h7F);
        busWr(`HBL_REG_IDLE, 32'h1);
        repeat (150) @(posedge clk);
        #1 chk("display", 32'h0, displayOn);
        busRd(`HBL_REG_ISR);
        chk("sleep", 32'h1, got[3]);
        watch(60);
        chk("pulse", 32'h3, seen[11:8]);
        busWr(`HBL_REG_IDLE, 32'h0);
        u_op.press(0, 30);
        chk("display", 32'h1, displayOn);
        repeat (200) @(posedge clk);
        #1 chk("display", 32'h1, displayOn);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        wrEn = 1'b0;
        rdEn = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_leds;
        t_irq;
        t_saver;
        t_logout;
        t_entry;
        t_qual;
        t_sleep;
        stop_test;
    end
endmodule // hbl_indicator_tb
`default_nettype wire
